//--- rtl/ssrm_regs.vh
// constants for the status readback mux
`ifndef SSRM_REGS_VH
`define SSRM_REGS_VH
// status select addresses
`define SSRM_ADDR_FAULT    3'h0
`define SSRM_ADDR_SENSE    3'h1
`define SSRM_ADDR_OCLEVEL  3'h2
`define SSRM_ADDR_TIMING   3'h3
`define SSRM_ADDR_DIRECT   3'h4
`define SSRM_ADDR_DLYWD    3'h5
`define SSRM_ADDR_PINS     3'h6
`define SSRM_ADDR_NULL     3'h7
// fault flag bit positions
`define SSRM_FLT_OT        6
`define SSRM_FLT_OCH       5
`define SSRM_FLT_OCL       4
`define SSRM_FLT_OL        3
`define SSRM_FLT_UV        2
`define SSRM_FLT_OV        1
`define SSRM_FLT_SUM       0
// reset values and word width
`define SSRM_FLT_RESET     7'h00
`define SSRM_ADDR_RESET    3'h7
`define SSRM_WORD_BITS     8
`endif

//--- rtl/ssrm_sync.v
// two flip-flop synchroniser for one level
module ssrm_sync (
   input  wire clock,
   input  wire reset_n,
   input  wire d,
   output reg  q
);
   reg meta_q;

   always @(posedge clock) begin
      if (!reset_n) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

//--- rtl/ssrm_top.v
// status readback mux with serial shifter and fault flags
// Function
// - address 000 returns fault flags on D6-D0
// - fault flag bit layout D6 to D0
// - overcurrent and undervoltage flags latch when set
// - summary fault is OR of others, held until a fault read
// - reading fault register clears summary fault
// - fault pin released only by switch-on
// - address 001 returns sense enable, switch-on
// - address 010 returns overcurrent level selections
// - address 011 returns dead-time, timeout, open-load
// - address 100 returns direct-input configuration
// - address 101 returns delay or watchdog setup
// - address 110 returns live pin levels
// - address 111 returns zeros in low bits
// - latch at chip-select rise, byte multiple only
// - later output bits repeat input bits
`include "ssrm_regs.vh"
module ssrm_top (
   input  wire       clock,
   input  wire       reset_n,
   input  wire       sclk,
   input  wire       cs_n,
   input  wire       si,
   output reg        so,
   output reg        so_oe,
   input  wire       ot_cond,
   input  wire       och_cond,
   input  wire       ocl_cond,
   input  wire       ol_cond,
   input  wire       uv_cond,
   input  wire       ov_cond,
   input  wire       current_sense_enable,
   input  wire       switch_on_cmd,
   input  wire       oc_high_level_sel,
   input  wire [2:0] oc_low_level_sel,
   input  wire [1:0] oc_dead_time,
   input  wire       oc_timeout_disable,
   input  wire       open_load_disable,
   input  wire [3:0] direct_input_config,
   input  wire [2:0] output_delay_sel,
   input  wire       watchdog_expired_flag,
   input  wire [1:0] watchdog_period_sel,
   input  wire       direct_in_pin,
   input  wire       failsafe_enable_pin,
   input  wire       wake_pin,
   input  wire       switch_on_event,
   output reg  [7:0] rx_word,
   output reg        rx_valid,
   output reg        fault_indicator_pin_n
);
   ////////////////////////////////////////////////////////////////////////////
   wire sclk_s;
   wire cs_act_s;
   wire cs_n_s;
   wire si_s;
   wire in_s;
   wire fsi_s;
   wire wake_s;

   ssrm_sync u_sclk (.clock(clock), .reset_n(reset_n), .d(sclk),   .q(sclk_s));
   // select synchronised active high, so reset reads as deselected
   ssrm_sync u_cs   (.clock(clock), .reset_n(reset_n), .d(~cs_n),  .q(cs_act_s));
   assign cs_n_s = ~cs_act_s;
   ssrm_sync u_si   (.clock(clock), .reset_n(reset_n), .d(si),     .q(si_s));
   ssrm_sync u_in   (.clock(clock), .reset_n(reset_n), .d(direct_in_pin), .q(in_s));
   ssrm_sync u_fsi  (.clock(clock), .reset_n(reset_n), .d(failsafe_enable_pin), .q(fsi_s));
   ssrm_sync u_wake (.clock(clock), .reset_n(reset_n), .d(wake_pin), .q(wake_s));

   reg sclk_q;
   reg cs_n_q;

   always @(posedge clock) begin
      if (!reset_n) begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sclk_q <= sclk_s;
         cs_n_q <= cs_n_s;
      end
   end

   wire sclk_rise = sclk_s & ~sclk_q;
   wire sclk_fall = ~sclk_s & sclk_q;
   wire cs_fall   = ~cs_n_s & cs_n_q;
   wire cs_rise   = cs_n_s & ~cs_n_q;
   wire active    = ~cs_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // fault flags
   reg  [6:0] flt_q;
   wire [6:1] raw = {ot_cond, och_cond, ocl_cond, ol_cond, uv_cond, ov_cond};
   reg        fault_read;
   wire [6:1] held;
   wire [6:1] flags;

   assign held  = {1'b0, flt_q[`SSRM_FLT_OCH], flt_q[`SSRM_FLT_OCL], 1'b0,
                   flt_q[`SSRM_FLT_UV], 1'b0};
   assign flags = raw | held;

   always @(posedge clock) begin
      if (!reset_n) begin
         flt_q <= `SSRM_FLT_RESET;
      end else begin
         flt_q[6:1] <= flags;
         // read clears summary, new fault wins
         if (|raw)
            flt_q[`SSRM_FLT_SUM] <= 1'b1;
         else if (fault_read)
            flt_q[`SSRM_FLT_SUM] <= 1'b0;
         else
            flt_q[`SSRM_FLT_SUM] <= flt_q[`SSRM_FLT_SUM] | (|flags);
         if (fault_read) begin
            flt_q[`SSRM_FLT_OCH] <= och_cond;
            flt_q[`SSRM_FLT_OCL] <= ocl_cond;
            flt_q[`SSRM_FLT_UV]  <= uv_cond;
         end
      end
   end

   always @(posedge clock) begin
      if (!reset_n)
         fault_indicator_pin_n <= 1'b1;
      else if (|raw)
         fault_indicator_pin_n <= 1'b0;
      else if (switch_on_event)
         fault_indicator_pin_n <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word select
   reg  [2:0] addr_q;
   reg        sub_q;
   reg        toggle_q;
   reg  [7:0] status_word;

   always @* begin
      status_word = {toggle_q, addr_q, 4'h0};
      case (addr_q)
         `SSRM_ADDR_FAULT:   status_word[6:0] = {flags, flt_q[`SSRM_FLT_SUM] | (|flags)};
         `SSRM_ADDR_SENSE:   status_word[1:0] = {current_sense_enable, switch_on_cmd};
         `SSRM_ADDR_OCLEVEL: status_word[3:0] = {oc_high_level_sel, oc_low_level_sel};
         `SSRM_ADDR_TIMING:  status_word[3:0] = {open_load_disable, oc_timeout_disable,
                                                 oc_dead_time};
         `SSRM_ADDR_DIRECT:  status_word[3:0] = direct_input_config;
         `SSRM_ADDR_DLYWD: begin
            status_word[7] = sub_q;
            if (sub_q)
               status_word[2:0] = {watchdog_expired_flag, watchdog_period_sel};
            else
               status_word[2:0] = output_delay_sel;
         end
         `SSRM_ADDR_PINS:    status_word[2:0] = {in_s, fsi_s, wake_s};
         default:            status_word[2:0] = 3'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial shifter
   reg [7:0] shift_q;
   reg [2:0] bitcnt_q;
   reg       bytes_q;

   always @(posedge clock) begin
      if (!reset_n) begin
         shift_q    <= 8'h00;
         bitcnt_q   <= 3'h0;
         bytes_q    <= 1'b0;
         so         <= 1'b0;
         so_oe      <= 1'b0;
         addr_q     <= `SSRM_ADDR_RESET;
         sub_q      <= 1'b0;
         toggle_q   <= 1'b0;
         rx_word    <= 8'h00;
         rx_valid   <= 1'b0;
         fault_read <= 1'b0;
      end else begin
         rx_valid   <= 1'b0;
         fault_read <= 1'b0;
         if (cs_fall) begin
            shift_q  <= status_word;
            so       <= status_word[7];
            so_oe    <= 1'b1;
            bitcnt_q <= 3'h0;
            bytes_q  <= 1'b0;
         end else if (active && sclk_rise) begin
            shift_q  <= {shift_q[6:0], si_s};
            bitcnt_q <= bitcnt_q + 3'h1;
            if (bitcnt_q == 3'h7)
               bytes_q <= 1'b1;
         end else if (active && sclk_fall) begin
            so <= shift_q[7];
         end else if (cs_rise) begin
            so_oe <= 1'b0;
            if (bytes_q && bitcnt_q == 3'h0) begin
               rx_word    <= shift_q;
               rx_valid   <= 1'b1;
               toggle_q   <= shift_q[7];
               fault_read <= (addr_q == `SSRM_ADDR_FAULT);
               if (shift_q[6:4] == 3'h0) begin
                  addr_q <= shift_q[2:0];
                  sub_q  <= shift_q[7];
               end
            end
         end
      end
   end
endmodule

//--- tb/spi_status_readback_mux_bench.sv
// self-checking bench for the status readback mux
module spi_status_readback_mux_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        switch_on_event = 1'b0;
   logic [5:0]  fc = 6'h00;
   logic [22:0] cfg = 23'h5B54ED;
   int          errors = 0, checks = 0;
   int          valids = 0;
   wire         sclk, cs_n, si, so, so_oe, rx_valid, fault_indicator_pin_n;
   wire  [7:0]  rx_word, pin = {7'h00, fault_indicator_pin_n};
   wire         ot_cond, och_cond, ocl_cond, ol_cond, uv_cond, ov_cond;
   wire         current_sense_enable, switch_on_cmd, oc_high_level_sel;
   wire  [2:0]  oc_low_level_sel, output_delay_sel;
   wire  [1:0]  oc_dead_time, watchdog_period_sel;
   wire         oc_timeout_disable, open_load_disable, watchdog_expired_flag;
   wire  [3:0]  direct_input_config;
   wire         direct_in_pin, failsafe_enable_pin, wake_pin;
   // command, expected word, bits that follow the inputs
   logic [23:0] rows [9] = '{24'h808000, 24'h819203, 24'h022D0F, 24'h83B60F, 24'h044A0F,
                             24'h055307, 24'h85D507, 24'h86E507, 24'h077000};
   assign {ot_cond, och_cond, ocl_cond, ol_cond, uv_cond, ov_cond} = fc;
   assign {current_sense_enable, switch_on_cmd, oc_high_level_sel, oc_low_level_sel,
           oc_dead_time, oc_timeout_disable, open_load_disable, direct_input_config,
           output_delay_sel, watchdog_expired_flag, watchdog_period_sel, direct_in_pin,
           failsafe_enable_pin, wake_pin} = cfg;
   ssrm_top dut (.*);
   ssrm_host h (.*);
   initial forever #2.5 clock = ~clock;
   // count accepted messages
   always @(negedge clock)
      if (rx_valid === 1'b1)
         valids++;
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", n, e, g);
         errors++;
      end
   endtask
   task final_report;
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      final_report;
   end
   initial begin
      logic [15:0] r;
      logic [23:0] w;
      int          v;
      repeat (3) @(posedge clock);
      chk("rx_word", 8'h00, rx_word);
      chk("oe pin", 8'h01, {6'h00, so_oe, fault_indicator_pin_n});
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      h.frame(8, 16'h0007, r);
      chk("null", 8'h70, r[7:0]);
      for (int p = 0; p < 2; p++) begin
         cfg <= p ? ~23'h5B54ED : 23'h5B54ED;
         foreach (rows[i]) begin
            w = rows[i];
            h.frame(8, {8'h00, w[23:16]}, r);
            h.frame(8, {8'h00, w[23:16]}, r);
            chk("word", w[15:8] ^ (p ? w[7:0] : 8'h00), r[7:0]);
         end
      end
      v = valids;
      h.frame(7, 16'h0001, r);
      chk("rx_word", 8'h07, rx_word);
      chk("rx_valid", 8'h00, 8'(valids - v));
      h.frame(16, 16'hC301, r);
      chk("kept", 8'h70, r[15:8]);
      chk("echo", 8'hC3, r[7:0]);
      chk("rx_word", 8'h01, rx_word);
      chk("rx_valid", 8'h01, 8'(valids - v));
      h.frame(8, 16'h0001, r);
      chk("last byte", 8'h11, r[7:0]);
      fc <= 6'h3F;
      repeat (4) @(posedge clock);
      fc <= 6'h20;
      h.frame(8, 16'h0000, r);
      h.frame(8, 16'h0000, r);
      chk("faults", 8'h75, r[7:0]);
      fc <= 6'h00;
      h.frame(8, 16'h0000, r);
      h.frame(8, 16'h0000, r);
      chk("cleared", 8'h00, r[7:0]);
      chk("pin held", 8'h00, pin);
      switch_on_event <= 1'b1;
      @(posedge clock);
      switch_on_event <= 1'b0;
      repeat (4) @(posedge clock);
      chk("pin freed", 8'h01, pin);
      final_report;
   end
endmodule

//--- tb/ssrm_checker.sv
// assertions on the readback mux pins
module ssrm_checker (
   input logic clock,
   input logic reset_n,
   input logic cs_n,
   input logic so_oe,
   input logic rx_valid,
   input logic fault_indicator_pin_n,
   input logic ot_cond,
   input logic switch_on_event
);
   timeunit 1ns;
   timeprecision 1ps;
   wire fp = fault_indicator_pin_n;
   wire ev = switch_on_event;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_oe_on; $fell(cs_n) |-> ##[1:6] so_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("so_oe late");
   property p_oe_off; $rose(cs_n) |-> ##[1:6] !so_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("so_oe stuck");
   property p_oe_hold; so_oe && !cs_n |=> so_oe; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("so_oe drop");
   property p_v_one; rx_valid |=> !rx_valid; endproperty
   a_v_one: assert property (p_v_one) else $error("rx_valid long");
   property p_v_cs; rx_valid |-> cs_n && !$past(cs_n, 6); endproperty
   a_v_cs: assert property (p_v_cs) else $error("rx_valid stray");
   property p_pin_set; ot_cond |-> ##[0:3] !fp; endproperty
   a_pin_set: assert property (p_pin_set) else $error("pin idle");
   property p_pin_rel; $rose(fp) |-> $past(ev) || $past(ev, 2); endproperty
   a_pin_rel: assert property (p_pin_rel) else $error("pin freed");
   property p_pin_ok; $rose(fp) |-> !$past(ot_cond); endproperty
   a_pin_ok: assert property (p_pin_ok) else $error("pin early");
endmodule
bind ssrm_top ssrm_checker chk (.*);

//--- tb/ssrm_host.sv
// spi host model that sends frames to the readback mux
module ssrm_host (
   input  logic clock,
   input  logic so,
   input  logic so_oe,
   output logic sclk = 1'b0,
   output logic cs_n = 1'b1,
   output logic si = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      cs_n <= 1'b0;
      repeat (8) @(posedge clock);
      for (int i = n - 1; i >= 0; i--) begin
         si <= tx[i];
         repeat (8) @(posedge clock);
         sclk <= 1'b1;
         rx[i] = so_oe ? so : 1'bx;
         repeat (8) @(posedge clock);
         sclk <= 1'b0;
      end
      repeat (8) @(posedge clock);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (16) @(posedge clock);
   endtask
endmodule
